// ### include/sbc_pkg.sv
package sbc_pkg;
  localparam int          SBC_NUM_CH        = 2;
  localparam int          SBC_AW            = 16;
  // register indices; byte address is four times the index
  localparam logic [13:0] SBC_CTRL_IDX [2]  = '{14'h011F, 14'h0A1F};
  localparam logic [13:0] SBC_CFG_IDX  [2]  = '{14'h0120, 14'h0A20};
  localparam logic [13:0] SBC_ABRES_IDX[2]  = '{14'h0121, 14'h0A21};
  localparam logic [13:0] SBC_INT_STAT_IDX  = 14'h0200;
  localparam logic [13:0] SBC_INT_MASK_IDX  = 14'h0201;
  // baud control field positions
  localparam int          SBC_B_OVF         = 7;
  localparam int          SBC_B_IDLE        = 6;
  localparam int          SBC_B_POL         = 4;
  localparam int          SBC_B_WIDE        = 3;
  localparam int          SBC_B_WAKE        = 1;
  localparam int          SBC_B_ABD         = 0;
  localparam logic [7:0]  SBC_CTRL_WMASK    = 8'h1B;
  localparam logic [7:0]  SBC_CTRL_RESET    = 8'h00;
  // config register: bit 16 synchronous mode, 15:0 rate divisor
  localparam int          SBC_C_SYNC        = 16;
  localparam logic [15:0] SBC_DIV_RESET     = 16'h0000;
  // interrupt status layout: two bits per channel
  localparam int          SBC_I_WAKE        = 0;
  localparam int          SBC_I_ABD         = 1;
  localparam int          SBC_INT_W         = 2 * SBC_NUM_CH;
  // timing
  localparam logic [3:0]  SBC_FRAME_BITS    = 4'hA;
  localparam logic [2:0]  SBC_ABD_EDGES     = 3'h5;
  localparam logic [15:0] SBC_ABD_MAX       = 16'hFFFF;

  typedef enum logic [1:0] {
    SBC_RX_IDLE = 2'b00,
    SBC_RX_RECV = 2'b01,
    SBC_RX_ABD  = 2'b10
  } sbc_rx_state_t;
endpackage : sbc_pkg

// ### rtl/sbc_baud_control.sv
`timescale 1ns/1ns
module sbc_baud_control
  import sbc_pkg::*;
(
  input  wire logic                  clock_in,
  input  wire logic                  reset_in,
  input  wire logic                  psel_in,
  input  wire logic                  penable_in,
  input  wire logic                  pwrite_in,
  input  wire logic [SBC_AW-1:0]     paddr_in,
  input  wire logic [31:0]           pwdata_in,
  input  wire logic [3:0]            pstrb_in,
  output logic      [31:0]           prdata_out,
  output logic                       pready_out,
  output logic                       pslverr_out,
  input  wire logic [SBC_NUM_CH-1:0] rx_pin_in,
  input  wire logic [SBC_NUM_CH-1:0] sync_clk_in,
  input  wire logic [SBC_NUM_CH-1:0] tx_data_in,
  output logic      [SBC_NUM_CH-1:0] tx_pin_out,
  output logic      [SBC_NUM_CH-1:0] sync_strobe_out,
  output logic      [SBC_NUM_CH-1:0] rate_tick_out,
  output logic                       irq_out
);

  logic [SBC_INT_W-1:0]  int_stat_r;
  logic [SBC_INT_W-1:0]  int_mask_r;
  logic [SBC_INT_W-1:0]  int_event;
  logic [31:0]           prdata_r;
  logic [31:0]           rd_ctrl  [SBC_NUM_CH];
  logic [31:0]           rd_cfg   [SBC_NUM_CH];
  logic [31:0]           rd_res   [SBC_NUM_CH];
  logic [SBC_NUM_CH-1:0] hit_ctrl;
  logic [SBC_NUM_CH-1:0] hit_cfg;
  logic [SBC_NUM_CH-1:0] hit_res;
  logic [31:0]           rd_mux;
  logic [31:0]           wmask;

  wire   setup_rd  = psel_in & ~penable_in & ~pwrite_in;
  wire   access_wr = psel_in & penable_in & pwrite_in;
  wire   hit_stat  = (paddr_in == {SBC_INT_STAT_IDX, 2'b00});
  wire   hit_mask  = (paddr_in == {SBC_INT_MASK_IDX, 2'b00});
  wire   hit_any   = hit_stat | hit_mask | (|hit_ctrl) | (|hit_cfg) | (|hit_res);
  wire   wr_stat   = access_wr & hit_stat;
  wire   wr_mask   = access_wr & hit_mask;

  assign wmask       = {{8{pstrb_in[3]}}, {8{pstrb_in[2]}}, {8{pstrb_in[1]}}, {8{pstrb_in[0]}}};
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~hit_any;
  assign prdata_out  = prdata_r;
  assign irq_out     = |(int_stat_r & int_mask_r);

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_stat) begin
      rd_mux = {{(32-SBC_INT_W){1'b0}}, int_stat_r};
    end else if (hit_mask) begin
      rd_mux = {{(32-SBC_INT_W){1'b0}}, int_mask_r};
    end else begin
      for (int i = 0; i < SBC_NUM_CH; i++) begin
        if (hit_ctrl[i]) begin
          rd_mux = rd_ctrl[i];
        end else if (hit_cfg[i]) begin
          rd_mux = rd_cfg[i];
        end else if (hit_res[i]) begin
          rd_mux = rd_res[i];
        end
      end
    end
  end

  // read data captured in setup so it is stable through the access phase
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_rd) begin
      prdata_r <= rd_mux;
    end
  end

  // sticky status, write one to clear; a same-cycle event wins
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      int_stat_r <= '0;
      int_mask_r <= '0;
    end else begin
      int_stat_r <= (int_stat_r & ~(wr_stat ? pwdata_in[SBC_INT_W-1:0] & wmask[SBC_INT_W-1:0] : '0))
                    | int_event;
      if (wr_mask) begin
        int_mask_r <= (int_mask_r & ~wmask[SBC_INT_W-1:0]) | (pwdata_in[SBC_INT_W-1:0] & wmask[SBC_INT_W-1:0]);
      end
    end
  end

  for (genvar ch = 0; ch < SBC_NUM_CH; ch++) begin : g_ch
    logic [7:0]    ctrl_r;
    logic          sync_r;
    logic [15:0]   div_r;
    logic [15:0]   res_r;
    logic          ovf_r;
    logic [15:0]   brg_cnt_r;
    logic [3:0]    bit_cnt_r;
    logic [15:0]   abd_cnt_r;
    logic [2:0]    abd_edge_r;
    sbc_rx_state_t state_r;
    logic          rx_s1_r;
    logic          rx_s2_r;
    logic          rx_d_r;
    logic          ck_s1_r;
    logic          ck_s2_r;
    logic          ck_d_r;
    logic          tx_r;
    logic          strobe_r;
    logic          wake_ev_r;
    logic          abd_ev_r;

    assign hit_ctrl[ch] = (paddr_in == {SBC_CTRL_IDX[ch], 2'b00});
    assign hit_cfg[ch]  = (paddr_in == {SBC_CFG_IDX[ch], 2'b00});
    assign hit_res[ch]  = (paddr_in == {SBC_ABRES_IDX[ch], 2'b00});
    assign rd_ctrl[ch]  = {24'h000000, ovf_r & ~sync_r, (state_r != SBC_RX_RECV) & ~sync_r, 1'b0,
                           ctrl_r[4:3], 1'b0, ctrl_r[1:0]};
    assign rd_cfg[ch]   = {15'h0000, sync_r, div_r};
    assign rd_res[ch]   = {16'h0000, res_r};

    wire wr_ctrl   = access_wr & hit_ctrl[ch] & pstrb_in[0];
    wire wr_cfg    = access_wr & hit_cfg[ch];
    wire polarity  = ctrl_r[SBC_B_POL];
    wire wide      = ctrl_r[SBC_B_WIDE];
    wire wake_en   = ctrl_r[SBC_B_WAKE];
    wire abd_en    = ctrl_r[SBC_B_ABD];
    wire rx_fall   = rx_d_r & ~rx_s2_r;
    wire ck_rise   = ~ck_d_r & ck_s2_r;
    wire ck_fall   = ck_d_r & ~ck_s2_r;
    wire [15:0] div_sel = wide ? div_r : {8'h00, div_r[7:0]};
    wire brg_tick  = (brg_cnt_r == 16'h0000);
    wire frame_end = brg_tick & (bit_cnt_r == SBC_FRAME_BITS - 4'h1);
    // first edge is taken on entry, so the fifth is the fourth one seen in measure state
    wire abd_done  = rx_fall & (abd_edge_r == SBC_ABD_EDGES - 3'h2);
    wire abd_ovf   = (abd_cnt_r == SBC_ABD_MAX);
    wire idle_fall = ~sync_r & (state_r == SBC_RX_IDLE) & rx_fall;
    wire do_wake   = idle_fall & wake_en;
    wire ctl_abd   = (state_r == SBC_RX_ABD) & ~sync_r;
    wire abd_fin   = ctl_abd & (abd_done | abd_ovf);
    wire [7:0] ctrl_wr  = (ctrl_r & ~SBC_CTRL_WMASK) | (pwdata_in[7:0] & SBC_CTRL_WMASK);
    wire [7:0] ctrl_sw  = wr_ctrl ? ctrl_wr : ctrl_r;
    wire [7:0] hw_clr   = {6'h00, do_wake, abd_fin};

    assign int_event[2*ch+SBC_I_WAKE] = wake_ev_r;
    assign int_event[2*ch+SBC_I_ABD]  = abd_ev_r;
    assign tx_pin_out[ch]      = tx_r;
    assign sync_strobe_out[ch] = strobe_r;
    assign rate_tick_out[ch]   = brg_tick;

    // pins are asynchronous to clock_in; only the second stage is looked at
    always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
        rx_s1_r <= 1'b1;
        rx_s2_r <= 1'b1;
        rx_d_r  <= 1'b1;
        ck_s1_r <= 1'b0;
        ck_s2_r <= 1'b0;
        ck_d_r  <= 1'b0;
      end else begin
        rx_s1_r <= rx_pin_in[ch];
        rx_s2_r <= rx_s1_r;
        rx_d_r  <= rx_s2_r;
        ck_s1_r <= sync_clk_in[ch];
        ck_s2_r <= ck_s1_r;
        ck_d_r  <= ck_s2_r;
      end
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
        tx_r     <= 1'b1;
        strobe_r <= 1'b0;
      end else begin
        tx_r     <= sync_r ? tx_data_in[ch] : tx_data_in[ch] ^ polarity;
        strobe_r <= sync_r & (polarity ? ck_rise : ck_fall);
      end
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
        brg_cnt_r <= 16'h0000;
      end else if (brg_tick) begin
        brg_cnt_r <= div_sel;
      end else begin
        brg_cnt_r <= brg_cnt_r - 16'h0001;
      end
    end

    // hardware clears of wake and autobaud enable override a write in the same cycle
    always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
        ctrl_r <= SBC_CTRL_RESET;
        sync_r <= 1'b0;
        div_r  <= SBC_DIV_RESET;
      end else begin
        ctrl_r <= ctrl_sw & ~hw_clr;
        if (wr_cfg & pstrb_in[2]) begin
          sync_r <= pwdata_in[SBC_C_SYNC];
        end
        if (wr_cfg & pstrb_in[0]) begin
          div_r[7:0] <= pwdata_in[7:0];
        end
        if (wr_cfg & pstrb_in[1]) begin
          div_r[15:8] <= pwdata_in[15:8];
        end
      end
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
        state_r    <= SBC_RX_IDLE;
        bit_cnt_r  <= 4'h0;
        abd_cnt_r  <= 16'h0000;
        abd_edge_r <= 3'h0;
        res_r      <= 16'h0000;
        ovf_r      <= 1'b0;
        wake_ev_r  <= 1'b0;
        abd_ev_r   <= 1'b0;
      end else begin
        wake_ev_r <= do_wake;
        abd_ev_r  <= abd_fin;
        if (wr_ctrl & pwdata_in[SBC_B_ABD]) begin
          ovf_r <= 1'b0;
        end
        if (sync_r) begin
          state_r <= SBC_RX_IDLE;
        end else begin
          case (state_r)
            SBC_RX_IDLE: begin
              if (rx_fall & ~wake_en & abd_en) begin
                state_r    <= SBC_RX_ABD;
                abd_cnt_r  <= 16'h0001;
                abd_edge_r <= 3'h0;
              end else if (rx_fall & ~wake_en) begin
                state_r   <= SBC_RX_RECV;
                bit_cnt_r <= 4'h0;
              end
            end
            SBC_RX_RECV: begin
              if (frame_end) begin
                state_r <= SBC_RX_IDLE;
              end else if (brg_tick) begin
                bit_cnt_r <= bit_cnt_r + 4'h1;
              end
            end
            SBC_RX_ABD: begin
              abd_cnt_r <= abd_cnt_r + 16'h0001;
              if (abd_ovf) begin
                ovf_r   <= 1'b1;
                state_r <= SBC_RX_IDLE;
              end else if (abd_done) begin
                res_r   <= abd_cnt_r;
                state_r <= SBC_RX_IDLE;
              end else if (rx_fall) begin
                abd_edge_r <= abd_edge_r + 3'h1;
              end
            end
            default: begin
              state_r <= SBC_RX_IDLE;
            end
          endcase
        end
      end
    end
  end

endmodule : sbc_baud_control

// ### verif/sbc_baud_control_asserts.sv
`timescale 1ns/1ns
module sbc_baud_control_asserts
  import sbc_pkg::*;
(
  input wire logic                  clock_in,
  input wire logic                  reset_in,
  input wire logic                  psel_in,
  input wire logic                  penable_in,
  input wire logic                  pwrite_in,
  input wire logic [SBC_AW-1:0]     paddr_in,
  input wire logic [31:0]           pwdata_in,
  input wire logic [3:0]            pstrb_in,
  input wire logic [31:0]           prdata_out,
  input wire logic                  pready_out,
  input wire logic                  pslverr_out,
  input wire logic [SBC_NUM_CH-1:0] tx_data_in,
  input wire logic [SBC_NUM_CH-1:0] tx_pin_out,
  input wire logic [SBC_NUM_CH-1:0] sync_strobe_out,
  input wire logic                  irq_out
);
  logic [SBC_NUM_CH-1:0] pol_r;
  logic [SBC_NUM_CH-1:0] sync_r;
  wire                   acc_w = psel_in && penable_in;
  wire                   wr_w  = acc_w && pwrite_in;
  wire                   rd1_w = acc_w && !pwrite_in && paddr_in == {SBC_CTRL_IDX[1], 2'b00};
  // shadow of mode bits, so the pin checks follow what software set
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      pol_r  <= '0;
      sync_r <= '0;
    end else if (wr_w) begin
      for (int c = 0; c < SBC_NUM_CH; c++) begin
        if (paddr_in == {SBC_CTRL_IDX[c], 2'b00} && pstrb_in[0]) pol_r[c] <= pwdata_in[SBC_B_POL];
        if (paddr_in == {SBC_CFG_IDX[c], 2'b00} && pstrb_in[2]) sync_r[c] <= pwdata_in[SBC_C_SYNC];
      end
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);
  sequence s_acc;
    psel_in && !penable_in ##1 acc_w;
  endsequence
  AST_PREADY: assert property (s_acc |-> pready_out) else $error("no ready in access phase");
  AST_SLVERR: assert property (pslverr_out |-> acc_w && (pwrite_in || prdata_out == '0))
    else $error("bad error response");
  AST_CTRL_RO: assert property (rd1_w |-> prdata_out[31:8] == '0 && !prdata_out[5] && !prdata_out[2])
    else $error("reserved control bits set");
  AST_SYNC_FLAGS: assert property (rd1_w && sync_r[1] |-> prdata_out[7:6] == 2'b00)
    else $error("status flags set in sync mode");
  AST_TX_POL: assert property (!$past(reset_in) |-> tx_pin_out == ($past(tx_data_in) ^ ($past(pol_r) & ~$past(sync_r))))
    else $error("transmit pin polarity wrong");
  AST_STROBE_PULSE: assert property (|sync_strobe_out |=> (sync_strobe_out & $past(sync_strobe_out)) == '0)
    else $error("strobe longer than one cycle");
  AST_STROBE_MODE: assert property ((sync_strobe_out & ~$past(sync_r)) == '0)
    else $error("strobe outside sync mode");
  AST_IRQ_FALL: assert property ($fell(irq_out) |-> $past(wr_w))
    else $error("interrupt dropped without a write");
endmodule : sbc_baud_control_asserts

bind sbc_baud_control sbc_baud_control_asserts i_asserts (.clock_in(clock_in), .reset_in(reset_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .tx_data_in(tx_data_in), .tx_pin_out(tx_pin_out),
  .sync_strobe_out(sync_strobe_out), .irq_out(irq_out));

// ### verif/sbc_line_model.sv
`timescale 1ns/1ns
module sbc_line_model
  import sbc_pkg::*;
(
  input  wire logic                  clock_in,
  output logic      [SBC_NUM_CH-1:0] rx_pin_out,
  output logic      [SBC_NUM_CH-1:0] sync_clk_out
);
  initial begin
    rx_pin_out   = '1;
    sync_clk_out = '0;
  end
  // frame goes out lsb first, len clocks a bit; line stays at frame[9] after
  task automatic send(input int ch, input logic [9:0] frame, input int len);
    for (int b = 0; b < 10; b++) begin
      @(posedge clock_in);
      rx_pin_out[ch] <= frame[b];
      repeat (len - 1) @(posedge clock_in);
    end
  endtask : send
  // clock stands still between calls
  task automatic set_clk(input int ch, input logic v);
    @(posedge clock_in);
    sync_clk_out[ch] <= v;
  endtask : set_clk
endmodule : sbc_line_model

// ### verif/tb_top.sv
`timescale 1ns/1ns
module tb_top import sbc_pkg::*;;
  localparam logic [15:0] CTRL0 = {SBC_CTRL_IDX[0], 2'b00};
  localparam logic [15:0] CTRL1 = {SBC_CTRL_IDX[1], 2'b00};
  localparam logic [15:0] CFG0  = {SBC_CFG_IDX[0], 2'b00};
  localparam logic [15:0] CFG1  = {SBC_CFG_IDX[1], 2'b00};
  localparam logic [15:0] ABR1  = {SBC_ABRES_IDX[1], 2'b00};
  localparam logic [15:0] STAT  = {SBC_INT_STAT_IDX, 2'b00};
  logic        clock_in, reset_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, irq_out, er;
  logic [15:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic [1:0]  rx_pin_in, sync_clk_in, tx_data_in, tx_pin_out, sync_strobe_out, rate_tick_out;
  int          err_count = 0, n_checks = 0, k;
  sbc_baud_control i_dut (.clock_in(clock_in), .reset_in(reset_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .pstrb_in(4'hF), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .rx_pin_in(rx_pin_in), .sync_clk_in(sync_clk_in), .tx_data_in(tx_data_in), .tx_pin_out(tx_pin_out),
    .sync_strobe_out(sync_strobe_out), .rate_tick_out(rate_tick_out), .irq_out(irq_out));
  sbc_line_model i_line (.clock_in(clock_in), .rx_pin_out(rx_pin_in), .sync_clk_out(sync_clk_in));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int g;
    g = 0;
    @(posedge clock_in);
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= w;
    paddr_in   <= a;
    pwdata_in  <= d;
    @(posedge clock_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clock_in);
      g++;
    end while (pready_out !== 1'b1 && g < 20);
    if (g >= 20) begin
      err_count++;
      finish_test();
    end
    rd = prdata_out;
    er = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [15:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc
  // s: 0 irq, 1 strobe, 2 rate tick; a missed must-wait ends the run
  task automatic wt(input int s, input int ch, input int n, input bit must, output int c);
    c = 0;
    do begin
      @(posedge clock_in);
      #1;
      c++;
    end while (!(s == 0 ? irq_out === 1'b1 : s == 1 ? sync_strobe_out[ch] === 1'b1 : rate_tick_out[ch] === 1'b1)
               && c < n);
    if (must && c >= n) begin
      err_count++;
      finish_test();
    end
  endtask : wt
  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  initial begin
    reset_in   = 1'b1;
    psel_in    = 1'b0;
    penable_in = 1'b0;
    pwrite_in  = 1'b0;
    paddr_in   = 16'h0000;
    pwdata_in  = 32'h0;
    tx_data_in = 2'b11;
    repeat (6) @(posedge clock_in);
    reset_in <= 1'b0;
    rdc(CTRL0, 32'h40);
    rdc(CFG0, 32'h0);
    apb(1'b0, 16'h0010, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, CTRL1, 32'hFF);
    rdc(CTRL1, 32'h5B);
    apb(1'b1, CTRL1, 32'h0);
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, CTRL0, p << SBC_B_POL);
      for (int d = 0; d < 2; d++) begin
        tx_data_in <= {2{d[0]}};
        repeat (3) @(posedge clock_in);
        chk(tx_pin_out[0], d[0] ^ p[0]);
      end
    end
    apb(1'b1, CFG0, 32'h0103);
    for (int w = 1; w >= 0; w--) begin
      apb(1'b1, CTRL0, w << SBC_B_WIDE);
      wt(2, 0, 300, 1, k);
      wt(2, 0, 300, 1, k);
      chk(k, w ? 32'h104 : 32'h4);
    end
    apb(1'b1, STAT + 16'h4, 32'hF);
    apb(1'b1, CTRL0, 32'h02);
    i_line.send(0, 10'h3FC, 2);
    wt(0, 0, 20, 1, k);
    rdc(STAT, 32'h1);
    rdc(CTRL0, 32'h40);
    apb(1'b1, STAT, 32'h1);
    #1;
    chk(irq_out, 1'b0);
    apb(1'b1, CTRL1, 32'h01);
    i_line.send(1, {1'b1, 8'h55, 1'b0}, 8);
    wt(0, 0, 20, 1, k);
    rdc(STAT, 32'h8);
    rdc(CTRL1, 32'h40);
    rdc(ABR1, 32'h40);
    apb(1'b1, STAT, 32'hF);
    fork
      i_line.send(0, 10'h200, 4);
      begin
        repeat (16) @(posedge clock_in);
        rdc(CTRL0, 32'h0);
      end
    join
    repeat (30) @(posedge clock_in);
    rdc(CTRL0, 32'h40);
    apb(1'b1, CTRL0, 32'h01);
    i_line.send(0, 10'h3FE, 2);
    repeat (65600) @(posedge clock_in);
    rdc(CTRL0, 32'hC0);
    rdc(STAT, 32'h2);
    apb(1'b1, CFG1, 32'h10000);
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, CTRL1, p << SBC_B_POL);
      rdc(CTRL1, p << SBC_B_POL);
      for (int v = 1; v >= 0; v--) begin
        i_line.set_clk(1, v[0]);
        wt(1, 1, 8, 0, k);
        chk(k < 8, v == p);
      end
    end
    finish_test();
  end
endmodule : tb_top
